// ---- inc/io_port_regs.vh ----
// register offsets, field positions and reset values of the port pin control
// ---------------------------------------------------------------------------
// Overview of operation
// R1 - port A pull-up active only when pin is input and enable bit set
// R2 - large variant port B has six pull-up enables, bits 7..6 unused
// R3 - in sleep or idle, enabled port A falling edge wakes device
// R4 - eight port A wake-up enable bits, all clear at reset
// R5 - direction bit 1 input, 0 output; resets to 1, all inputs
// R6 - reading an output pin returns its data latch, not the pin level
// R7 - large variant port B direction implements bits 5..0, rest read zero
// R8 - analog function wins over digital on a shared pin
// R9 - small variant even share bits pick timer0 outputs, odd bits read zero
// R10 - large variant share bits 7..5 pick timer0 outputs, bits 4..0 zero
// R11 - share bit a7 only acts while reset control holds 55H
// R12 - port B share bits 5..1 route timer1 or timer0 inverted outputs
// R13 - small variant timer0 clock from A7 or A6 by remap bit
// R14 - timer0 capture from A6 or A0 by remap bit
// R15 - small variant interrupt from A5, A2, A3 or A7
// R16 - unimplemented remap and share bits ignore writes and read zero
// R17 - large variant timer1 clock from A4, A6, A7 or B1
// R18 - large variant timer0 clock from A3 or A2
// R19 - large variant timer1 capture from A5 or B0
// R20 - large variant interrupt from A3, A2, A4 or A5
// R21 - remapped input takes signal only from the selected pin
// R22 - selected timer output drives the pin instead of the data latch
// ---------------------------------------------------------------------------
`ifndef IO_PORT_REGS_VH
`define IO_PORT_REGS_VH
`define OFS_PORT_A_DATA 12'h000
`define OFS_PORT_A_DIRECTION 12'h004
`define OFS_PORT_A_PULLUP 12'h008
`define OFS_PORT_A_WAKEUP 12'h00C
`define OFS_PORT_B_DATA 12'h010
`define OFS_PORT_B_DIRECTION 12'h014
`define OFS_PORT_B_PULLUP 12'h018
`define OFS_PORT_A_SHARE 12'h01C
`define OFS_PORT_B_SHARE 12'h020
`define OFS_INPUT_REMAP 12'h024
`define OFS_RESET_CONTROL 12'h028
`define OFS_PIN_LEVEL 12'h02C
`define RST_DATA 8'hFF
`define RST_DIRECTION 8'hFF
`define RST_CLEAR 8'h00
`define RST_RESET_CONTROL 8'h55
`define SHARE_A7_KEY 8'h55
`define MASK_A_SHARE_SMALL 8'h55
`define MASK_A_SHARE_LARGE 8'hE0
`define MASK_B_PORT 8'h3F
`define MASK_B_SHARE 8'h3E
`define MASK_REMAP_SMALL 8'h33
`define MASK_REMAP_LARGE 8'hFB
`define BIT_T0_CLK_REMAP 5
`define BIT_T0_CAP_REMAP 4
`define BIT_T1_CAP_REMAP 3
`endif

// ---- core/io_port_pin_control.v ----
// general purpose port pin control with apb register access
`include "io_port_regs.vh"

module io_port_pin_control #(
    parameter LARGE = 1
) (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] pa_in,
    output reg [7:0] pa_out,
    output reg [7:0] pa_oe,
    output reg [7:0] pa_pullup,
    input wire [5:0] pb_in,
    output reg [5:0] pb_out,
    output reg [5:0] pb_oe,
    output reg [5:0] pb_pullup,
    input wire [7:0] pa_analog_sel,
    input wire [5:0] pb_analog_sel,
    output reg [7:0] pa_analog_en,
    output reg [5:0] pb_analog_en,
    input wire low_power,
    output reg wakeup,
    input wire timer0_output,
    input wire timer0_output_inverted,
    input wire timer1_output,
    input wire timer1_output_inverted,
    output reg timer0_clock_input,
    output reg timer0_capture_input,
    output reg timer1_clock_input,
    output reg timer1_capture_input,
    output reg irq_input
);
    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    reg [7:0] pa_data_q;
    reg [7:0] port_a_direction_q;
    reg [7:0] port_a_pullup_enable_q;
    reg [7:0] port_a_wakeup_enable_q;
    reg [5:0] pb_data_q;
    reg [5:0] port_b_direction_q;
    reg [5:0] port_b_pullup_enable_q;
    reg [7:0] port_a_share_select_q;
    reg [7:0] port_b_share_select_q;
    reg [7:0] input_remap_q;
    reg [7:0] reset_control_reg_q;
    reg [7:0] pa_prev_q;

    wire [7:0] a_share_mask;
    wire [7:0] remap_mask;
    wire wr_en;
    wire rd_en;
    wire [7:0] wbyte;
    wire share_bit_a7;
    reg [7:0] pa_read;
    reg [7:0] pb_read;
    reg [7:0] rdata_d;
    reg hit_d;
    reg [7:0] pa_drive;
    reg [5:0] pb_drive;
    reg [1:0] irq_sel;
    reg [1:0] t1_sel;

    assign a_share_mask = LARGE ? `MASK_A_SHARE_LARGE : `MASK_A_SHARE_SMALL;
    assign remap_mask = LARGE ? `MASK_REMAP_LARGE : `MASK_REMAP_SMALL;
    assign wr_en = psel & penable & pwrite & ~pready;
    assign rd_en = psel & penable & ~pwrite & ~pready;
    assign wbyte = pwdata[7:0];
    assign share_bit_a7 = port_a_share_select_q[7] &
        (reset_control_reg_q == `SHARE_A7_KEY); // R11

    // pin read: input pins give level, output pins give latch
    function [7:0] pin_read;
        input [7:0] dir;
        input [7:0] lvl;
        input [7:0] latch;
        begin
            pin_read = (dir & lvl) | (~dir & latch);
        end
    endfunction

    always @* begin
        pa_read = pin_read(port_a_direction_q, pa_in, pa_data_q); // R6
        pb_read = pin_read({2'b00, port_b_direction_q}, {2'b00, pb_in},
            {2'b00, pb_data_q}); // R6
    end

    // ------------------------------------------------------------------
    // apb slave: one wait state, answer in second access cycle
    // ------------------------------------------------------------------
    always @* begin
        hit_d = 1'b1;
        rdata_d = 8'h00;
        case (paddr)
            `OFS_PORT_A_DATA: rdata_d = pa_read;
            `OFS_PORT_A_DIRECTION: rdata_d = port_a_direction_q;
            `OFS_PORT_A_PULLUP: rdata_d = port_a_pullup_enable_q;
            `OFS_PORT_A_WAKEUP: rdata_d = port_a_wakeup_enable_q;
            `OFS_PORT_B_DATA: rdata_d = pb_read;
            `OFS_PORT_B_DIRECTION: rdata_d = {2'b00, port_b_direction_q}; // R7
            `OFS_PORT_B_PULLUP: rdata_d = {2'b00, port_b_pullup_enable_q}; // R2
            `OFS_PORT_A_SHARE: rdata_d = port_a_share_select_q;
            `OFS_PORT_B_SHARE: rdata_d = port_b_share_select_q;
            `OFS_INPUT_REMAP: rdata_d = input_remap_q;
            `OFS_RESET_CONTROL: rdata_d = reset_control_reg_q;
            `OFS_PIN_LEVEL: rdata_d = pa_in;
            default: hit_d = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit_d;
            prdata <= rd_en ? {24'h00_0000, rdata_d} : 32'h0000_0000;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            pa_data_q <= `RST_DATA;
            port_a_direction_q <= `RST_DIRECTION; // R5
            port_a_pullup_enable_q <= `RST_CLEAR; // R1
            port_a_wakeup_enable_q <= `RST_CLEAR; // R4
            pb_data_q <= 6'h3F;
            port_b_direction_q <= 6'h3F; // R5
            port_b_pullup_enable_q <= 6'h00; // R2
            port_a_share_select_q <= `RST_CLEAR;
            port_b_share_select_q <= `RST_CLEAR;
            input_remap_q <= `RST_CLEAR;
            reset_control_reg_q <= `RST_RESET_CONTROL;
        end else if (wr_en) begin
            case (paddr)
                `OFS_PORT_A_DATA: pa_data_q <= wbyte;
                `OFS_PORT_A_DIRECTION: port_a_direction_q <= wbyte;
                `OFS_PORT_A_PULLUP: port_a_pullup_enable_q <= wbyte;
                `OFS_PORT_A_WAKEUP: port_a_wakeup_enable_q <= wbyte;
                `OFS_PORT_B_DATA: pb_data_q <= wbyte[5:0];
                `OFS_PORT_B_DIRECTION: port_b_direction_q <= wbyte[5:0];
                `OFS_PORT_B_PULLUP: port_b_pullup_enable_q <= wbyte[5:0];
                `OFS_PORT_A_SHARE:
                    port_a_share_select_q <= wbyte & a_share_mask; // R16
                `OFS_PORT_B_SHARE:
                    port_b_share_select_q <= wbyte &
                        (LARGE ? `MASK_B_SHARE : 8'h00); // R16
                `OFS_INPUT_REMAP:
                    input_remap_q <= wbyte & remap_mask; // R16
                `OFS_RESET_CONTROL: reset_control_reg_q <= wbyte;
                default: pa_data_q <= pa_data_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin sharing and drive
    // ------------------------------------------------------------------
    always @* begin
        pa_drive = pa_data_q;
        pb_drive = pb_data_q;
        if (LARGE) begin
            if (share_bit_a7) pa_drive[7] = timer0_output_inverted; // R10 R22
            if (port_a_share_select_q[6]) pa_drive[6] = timer0_output; // R10
            if (port_a_share_select_q[5]) pa_drive[4] = timer0_output; // R10
            if (port_b_share_select_q[5]) pb_drive[5] = timer1_output; // R12
            if (port_b_share_select_q[4])
                pb_drive[4] = timer1_output_inverted; // R12
            if (port_b_share_select_q[3]) pb_drive[3] = timer1_output; // R12
            if (port_b_share_select_q[2])
                pb_drive[2] = timer1_output_inverted; // R12
            if (port_b_share_select_q[1])
                pb_drive[1] = timer0_output_inverted; // R12 R22
        end else begin
            if (port_a_share_select_q[6])
                pa_drive[5] = timer0_output_inverted; // R9 R22
            if (port_a_share_select_q[4]) pa_drive[2] = timer0_output; // R9
            if (port_a_share_select_q[2])
                pa_drive[1] = timer0_output_inverted; // R9
            if (port_a_share_select_q[0]) pa_drive[0] = timer0_output; // R9
        end
        irq_sel = input_remap_q[1:0];
        t1_sel = input_remap_q[7:6];
    end

    // ------------------------------------------------------------------
    // registered outputs, remapped inputs and wake-up
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            pa_out <= 8'h00;
            pa_oe <= 8'h00;
            pa_pullup <= 8'h00;
            pb_out <= 6'h00;
            pb_oe <= 6'h00;
            pb_pullup <= 6'h00;
            pa_analog_en <= 8'h00;
            pb_analog_en <= 6'h00;
            wakeup <= 1'b0;
            pa_prev_q <= 8'hFF;
            timer0_clock_input <= 1'b0;
            timer0_capture_input <= 1'b0;
            timer1_clock_input <= 1'b0;
            timer1_capture_input <= 1'b0;
            irq_input <= 1'b0;
        end else begin
            pa_analog_en <= pa_analog_sel; // R8
            pb_analog_en <= LARGE ? pb_analog_sel : 6'h00; // R8
            pa_out <= pa_drive;
            pa_oe <= ~port_a_direction_q & ~pa_analog_sel; // R5 R8
            pb_out <= LARGE ? pb_drive : 6'h00;
            pb_oe <= LARGE ? (~port_b_direction_q & ~pb_analog_sel) : 6'h00;
            pa_pullup <= port_a_direction_q & port_a_pullup_enable_q &
                ~pa_analog_sel; // R1 R8
            pb_pullup <= LARGE ? (port_b_direction_q &
                port_b_pullup_enable_q & ~pb_analog_sel) : 6'h00; // R2
            pa_prev_q <= pa_in;
            wakeup <= low_power &
                (|(pa_prev_q & ~pa_in & port_a_wakeup_enable_q)); // R3 R4
            // R21
            if (LARGE) begin
                timer0_clock_input <= input_remap_q[`BIT_T0_CLK_REMAP] ?
                    pa_in[2] : pa_in[3]; // R18
                timer1_capture_input <= input_remap_q[`BIT_T1_CAP_REMAP] ?
                    pb_in[0] : pa_in[5]; // R19
                case (t1_sel)
                    2'b00: timer1_clock_input <= pa_in[4]; // R17
                    2'b01: timer1_clock_input <= pa_in[6];
                    2'b10: timer1_clock_input <= pa_in[7];
                    default: timer1_clock_input <= pb_in[1];
                endcase
                case (irq_sel)
                    2'b00: irq_input <= pa_in[3]; // R20
                    2'b01: irq_input <= pa_in[2];
                    2'b10: irq_input <= pa_in[4];
                    default: irq_input <= pa_in[5];
                endcase
            end else begin
                timer0_clock_input <= input_remap_q[`BIT_T0_CLK_REMAP] ?
                    pa_in[6] : pa_in[7]; // R13
                timer1_capture_input <= 1'b0;
                timer1_clock_input <= 1'b0;
                case (irq_sel)
                    2'b00: irq_input <= pa_in[5]; // R15
                    2'b01: irq_input <= pa_in[2];
                    2'b10: irq_input <= pa_in[3];
                    default: irq_input <= pa_in[7];
                endcase
            end
            timer0_capture_input <= input_remap_q[`BIT_T0_CAP_REMAP] ?
                pa_in[0] : pa_in[6]; // R14
        end
    end
endmodule // io_port_pin_control

// ---- verification/io_port_sva.sv ----
// assertions on the port pin control ports
module io_port_sva (
    input logic clk,
    input logic nrst,
    input logic psel,
    input logic penable,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [7:0] pa_oe,
    input logic [7:0] pa_pullup,
    input logic [5:0] pb_oe,
    input logic [5:0] pb_pullup,
    input logic [7:0] pa_analog_en,
    input logic low_power,
    input logic wakeup
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_req;
        psel && penable && !pready;
    endsequence
    sequence s_ans;
        pready ##1 !pready;
    endsequence
    a_access_answer: assert property (s_req |=> s_ans)
        else $error("access not answered by one pready pulse");
    a_pull_input: assert property ((pa_pullup & pa_oe) == 8'h00 &&
        (pb_pullup & pb_oe) == 6'h00) else $error("pull-up on output");
    a_analog_wins: assert property (
        (pa_analog_en & (pa_oe | pa_pullup)) == 8'h00)
        else $error("digital drive on analog pin");
    a_wake_cause: assert property (wakeup |-> $past(low_power))
        else $error("wakeup outside low power");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside answer");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_reset_inputs: assert property (@(posedge clk) disable iff (1'b0)
        !nrst |=> pa_oe == 8'h00 && pa_pullup == 8'h00)
        else $error("pins not inputs in reset");
endmodule // io_port_sva

// ---- verification/pin_switches.sv ----
// external switches and loads on one port's pins
module pin_switches #(
    parameter int W = 8
) (
    input logic clk,
    input logic [W-1:0] out_v,
    input logic [W-1:0] oe,
    input logic [W-1:0] pull_on,
    input logic [W-1:0] sw_en,
    input logic [W-1:0] sw_v,
    input logic [W-1:0] short_v,
    output logic [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] flt = '0;
    logic [W-1:0] drv;
    logic [W-1:0] ext;
    // an undriven pin with its switch off and no pull-up wanders every cycle
    always @(posedge clk) flt <= ~flt;
    assign drv = oe & ~short_v;
    assign ext = (sw_en & sw_v) | (~sw_en & (pull_on | flt));
    assign level = (drv & out_v) | (~drv & ext);
endmodule // pin_switches

// ---- verification/io_port_pin_control_tb.sv ----
// self-checking bench for the port pin control block
`include "io_port_regs.vh"
module io_port_pin_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, wakeup, e, seen, low_power = 0;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pullup, pa_analog_en;
    logic [5:0] pb_in, pb_out, pb_oe, pb_pullup, pb_analog_en;
    logic [7:0] pa_analog_sel = '0, sw_a = 8'hFF, sh_a = '0, sw_en_a = 8'hFF;
    logic [5:0] pb_analog_sel = '0, sw_b = 6'h3F, sw_en_b = 6'h3F, sh_b = '0;
    logic timer0_output = 0, timer0_output_inverted = 1;
    logic timer1_output = 0, timer1_output_inverted = 1;
    logic timer0_clock_input, timer0_capture_input, timer1_clock_input;
    logic timer1_capture_input, irq_input;
    int errors = 0, n_tests = 0;
    io_port_pin_control #(.LARGE(1)) dut (.clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pa_in,
        .pa_out, .pa_oe, .pa_pullup, .pb_in, .pb_out, .pb_oe, .pb_pullup,
        .pa_analog_sel, .pb_analog_sel, .pa_analog_en, .pb_analog_en,
        .low_power, .wakeup, .timer0_output, .timer0_output_inverted,
        .timer1_output, .timer1_output_inverted, .timer0_clock_input,
        .timer0_capture_input, .timer1_clock_input, .timer1_capture_input,
        .irq_input);
    pin_switches #(.W(8)) sw_pa (.clk, .out_v(pa_out), .oe(pa_oe),
        .pull_on(pa_pullup), .sw_en(sw_en_a), .sw_v(sw_a), .short_v(sh_a),
        .level(pa_in));
    pin_switches #(.W(6)) sw_pb (.clk, .out_v(pb_out), .oe(pb_oe),
        .pull_on(pb_pullup), .sw_en(sw_en_b), .sw_v(sw_b), .short_v(sh_b),
        .level(pb_in));
    initial forever #5 clk = ~clk;
    initial begin
        #300000;
        errors++;
        conclude;
    end
    task automatic conclude;
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask
    task automatic watch;
        seen = 0;
        repeat (4) begin
            @(posedge clk);
            seen = seen | wakeup;
        end
    endtask
    task automatic t_regs;
        logic [11:0] ofs [5] = '{`OFS_PORT_B_PULLUP, `OFS_PORT_B_DIRECTION,
            `OFS_INPUT_REMAP, `OFS_PORT_A_SHARE, `OFS_PORT_B_SHARE};
        logic [7:0] msk [5] = '{8'h3F, 8'h3F, 8'hFB, 8'hE0, 8'h3E};
        rd(`OFS_PORT_A_DIRECTION, 32'hFF);
        rd(`OFS_PORT_A_PULLUP, 32'h0);
        rd(`OFS_PORT_A_WAKEUP, 32'h0);
        rd(`OFS_PORT_B_DIRECTION, 32'h3F);
        rd(`OFS_PORT_B_PULLUP, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hFFFFFFFF);
            rd(ofs[i], {24'h0, msk[i]});
            wr(ofs[i], 32'h0);
        end
        // port B pins back to inputs so the remap scenario sees the switches
        wr(`OFS_PORT_B_DIRECTION, 32'h3F);
        wr(12'h030, 32'hFF);
        chk(e, 1'b1);
        rd(12'h030, 32'h0);
        chk(e, 1'b1);
    endtask
    task automatic t_pins;
        wr(`OFS_PORT_A_PULLUP, 32'hFF);
        wr(`OFS_PORT_A_DATA, 32'h5A);
        wr(`OFS_PORT_A_DIRECTION, 32'hF0);
        sh_a <= 8'h0F;
        sw_a <= 8'h3C;
        settle;
        chk(pa_pullup, 32'hF0);
        chk(pa_oe, 32'h0F);
        rd(`OFS_PORT_A_DATA, 32'h3A);
        pa_analog_sel <= 8'h01;
        settle;
        chk({pa_analog_en, pa_oe}, 32'h010E);
        pa_analog_sel <= 8'h00;
        sh_a <= 8'h00;
        wr(`OFS_PORT_A_DIRECTION, 32'hFF);
    endtask
    task automatic t_share;
        wr(`OFS_PORT_A_DATA, 32'h0);
        wr(`OFS_PORT_B_DATA, 32'h0);
        wr(`OFS_PORT_A_SHARE, 32'hE0);
        wr(`OFS_PORT_B_SHARE, 32'h3E);
        timer0_output <= 1'b1;
        timer0_output_inverted <= 1'b0;
        settle;
        chk({pa_out, 2'b00, pb_out}, 32'h5014);
        timer0_output <= 1'b0;
        timer0_output_inverted <= 1'b1;
        timer1_output <= 1'b1;
        timer1_output_inverted <= 1'b0;
        settle;
        chk({pa_out, 2'b00, pb_out}, 32'h802A);
        wr(`OFS_RESET_CONTROL, 32'h0);
        settle;
        chk(pa_out, 32'h00);
        wr(`OFS_RESET_CONTROL, 32'h55);
        wr(`OFS_PORT_A_SHARE, 32'h0);
    endtask
    task automatic t_remap;
        int ia [4] = '{3, 2, 4, 5};
        int ic [4] = '{4, 6, 7, 9};
        logic [13:0] v;
        logic [7:0] c;
        for (int k = 0; k < 4; k++) begin
            c = k;
            wr(`OFS_INPUT_REMAP, {24'h0, c[1:0], {3{c[0]}}, 1'b0, c[1:0]});
            for (int p = 0; p < 2; p++) begin
                sw_a <= p ? 8'hA5 : 8'h5A;
                sw_b <= p ? 6'h2A : 6'h15;
                settle;
                v = {sw_b, sw_a};
                chk(irq_input, v[ia[k]]);
                chk(timer1_clock_input, v[ic[k]]);
                chk(timer0_clock_input, c[0] ? v[2] : v[3]);
                chk(timer0_capture_input, c[0] ? v[0] : v[6]);
                chk(timer1_capture_input, c[0] ? v[8] : v[5]);
            end
        end
    endtask
    task automatic t_wake;
        wr(`OFS_PORT_A_WAKEUP, 32'h01);
        sw_a <= 8'hFF;
        low_power <= 1'b1;
        settle;
        sw_a <= 8'hFD;
        watch;
        chk(seen, 1'b0);
        sw_a <= 8'hFC;
        watch;
        chk(seen, 1'b1);
        low_power <= 1'b0;
        sw_a <= 8'hFF;
        settle;
        sw_a <= 8'hFE;
        watch;
        chk(seen, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_pins;
        t_share;
        t_remap;
        t_wake;
        conclude;
    end
endmodule // io_port_pin_control_tb
bind io_port_pin_control io_port_sva chk_i (.clk, .nrst, .psel, .penable,
    .prdata, .pready, .pslverr, .pa_oe, .pa_pullup, .pb_oe, .pb_pullup,
    .pa_analog_en, .low_power, .wakeup);
